// >>> logic/pmc_regs.sv
// management-interface register subset: straps, expanded control, interrupts
//
// Operation
// R1 - bit 17.5 reads 1 when strapped into NAND tree test mode
// R2 - reduced-pin variant: bit 17.1 reads 1 when strapped for RMII
// R3 - full-MII variant: bit 17.0 reads 1 when strapped for MII
// R4 - bit 18.11 disables energy-detect power-down when 1; resets to 1
// R5 - full-MII variant: bit 18.10 selects random receive latency; resets 0
// R6 - 100BASE-TX receive path forwards every preamble byte
// R7 - bit 18.6 set restores received 10BASE-T preamble; resets 0
// R8 - bit 18.6 clear strips seven preamble bytes, frame starts at SFD
// R9 - bit 1B.15 enables jabber interrupt; resets 0
// R10 - bit 1B.14 enables receive error interrupt; resets 0
// R11 - bit 1B.13 enables page received interrupt; resets 0
// R12 - bit 1B.12 enables parallel detect fault interrupt; resets 0
// R13 - bit 1B.11 enables link partner acknowledge interrupt; resets 0
// R14 - bit 1B.10 enables link-down interrupt; resets 0
// R15 - bit 1B.9 enables remote fault interrupt; resets 0
// R16 - bit 1B.8 enables link-up interrupt; resets 0
// R17 - low-byte status bits set on event, clear when register is read
// R18 - interrupt asserted while any enabled status bit is set
// R19 - straps sampled after reset, held until next reset, writes ignored
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_regs #(
    parameter logic       MII_VARIANT = 1'b1,
    parameter logic [4:0] PHY_ADDR    = 5'h01
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_o,
    input  wire logic       strap_nand_i,
    input  wire logic       strap_rmii_i,
    input  wire logic       strap_mii_i,
    input  wire logic [7:0] evt_i,
    input  wire logic       rx_mode10_i,
    input  wire logic       rx_dv_i,
    input  wire logic [3:0] rxd_i,
    output logic            rx_dv_o,
    output logic      [3:0] rxd_o,
    output logic            intr_o,
    output logic            energy_detect_powerdown_en_o,
    output logic            rx_latency_random_o
);

    // ======================================================================
    // state
    typedef struct packed {
        logic                  mdc_prev;
        pmc_pkg::pmc_mdio_st_t st;
        logic                  pre_ok;
        logic [3:0]            cnt;
        logic                  is_rd;
        logic [15:0]           shreg;
        logic                  mdio;
        logic                  mdio_oe;
        logic                  wr_stb;
        logic [4:0]            wr_addr;
        logic [15:0]           wr_data;
        logic [15:0]           xctrl;
        logic [7:0]            int_en;
        logic [7:0]            int_st;
        logic [2:0]            strap;
        logic [1:0]            strap_cnt;
        logic                  strap_done;
        logic                  intr;
        logic                  pwrdn_en;
        logic                  lat_rand;
    } pmc_regs_t;

    localparam pmc_regs_t RST_VAL = '{
        mdc_prev:   1'b0,
        st:         pmc_pkg::pmc_idle,
        pre_ok:     1'b0,
        cnt:        4'h0,
        is_rd:      1'b0,
        shreg:      16'h0000,
        mdio:       1'b0,
        mdio_oe:    1'b0,
        wr_stb:     1'b0,
        wr_addr:    5'h00,
        wr_data:    16'h0000,
        xctrl:      `PMC_XCTRL_RST,
        int_en:     `PMC_INT_EN_RST,
        int_st:     `PMC_INT_ST_RST,
        strap:      3'h0,
        strap_cnt:  2'h0,
        strap_done: 1'b0,
        intr:       1'b0,
        pwrdn_en:   1'b0,
        lat_rand:   1'b0
    };

    pmc_regs_t  q_reg;
    pmc_regs_t  q_next;
    logic [4:0] sync_q;
    logic       mdc_s;
    logic       mdio_s;
    logic       mdc_rise;
    logic       rd_clr;
    logic [1:0] hdr_op;
    logic [4:0] hdr_phy;
    logic [4:0] hdr_reg;
    logic [15:0] hdr_bits;

    // ======================================================================
    // pin synchronisers
    pmc_sync #(
        .W (5)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({strap_nand_i, strap_rmii_i, strap_mii_i, mdio_i, mdc_i}),
        .q_o     (sync_q)
    );

    assign mdc_s  = sync_q[0];
    assign mdio_s = sync_q[1];

    // ======================================================================
    // read decode
    function automatic logic [15:0] rd_data(
        input logic [4:0]  addr,
        input logic [2:0]  strap,
        input logic [15:0] xctrl,
        input logic [7:0]  int_en,
        input logic [7:0]  int_st
    );
        logic [15:0] d;
        d = 16'h0000;
        if (addr == `PMC_REG_STRAP) begin
            d[`PMC_BIT_NAND] = strap[2]; // R1
            d[`PMC_BIT_RMII] = strap[1] && !MII_VARIANT; // R2
            d[`PMC_BIT_MII]  = strap[0] && MII_VARIANT; // R3
        end else if (addr == `PMC_REG_XCTRL) begin
            d = xctrl;
        end else if (addr == `PMC_REG_INT) begin
            d = {int_en, int_st};
        end
        return d;
    endfunction

    // ======================================================================
    // next state
    always_comb begin
        q_next          = q_reg;
        mdc_rise        = mdc_s && !q_reg.mdc_prev;
        q_next.mdc_prev = mdc_s;
        q_next.wr_stb   = 1'b0;
        rd_clr          = 1'b0;
        hdr_bits        = {q_reg.shreg[14:0], mdio_s};
        hdr_op          = hdr_bits[11:10];
        hdr_phy         = hdr_bits[9:5];
        hdr_reg         = hdr_bits[4:0];

        // management frame engine
        if (mdc_rise) begin
            case (q_reg.st)
                pmc_pkg::pmc_idle: begin
                    q_next.mdio_oe = 1'b0;
                    q_next.pre_ok  = mdio_s;
                    if (!mdio_s && q_reg.pre_ok) begin
                        q_next.st = pmc_pkg::pmc_start;
                    end
                end
                pmc_pkg::pmc_start: begin
                    q_next.cnt   = 4'h0;
                    q_next.shreg = 16'h0000;
                    q_next.st    = mdio_s ? pmc_pkg::pmc_hdr : pmc_pkg::pmc_idle;
                end
                pmc_pkg::pmc_hdr: begin
                    q_next.shreg = hdr_bits;
                    q_next.cnt   = q_reg.cnt + 4'h1;
                    if (q_reg.cnt == `PMC_HDR_LAST) begin
                        q_next.cnt    = 4'h0;
                        q_next.is_rd  = (hdr_op == `PMC_OP_RD);
                        q_next.wr_addr = hdr_reg;
                        if (hdr_phy != PHY_ADDR || (hdr_op != `PMC_OP_RD
                                && hdr_op != `PMC_OP_WR)) begin
                            q_next.st     = pmc_pkg::pmc_idle;
                            q_next.pre_ok = 1'b0;
                        end else begin
                            q_next.st = pmc_pkg::pmc_ta;
                            if (hdr_op == `PMC_OP_RD) begin
                                q_next.shreg = rd_data(hdr_reg, q_reg.strap, q_reg.xctrl,
                                                       q_reg.int_en, q_reg.int_st);
                                rd_clr       = (hdr_reg == `PMC_REG_INT);
                            end
                        end
                    end
                end
                pmc_pkg::pmc_ta: begin
                    q_next.cnt = q_reg.cnt + 4'h1;
                    if (q_reg.is_rd) begin
                        q_next.mdio_oe = 1'b1;
                        q_next.mdio    = 1'b0;
                    end
                    if (q_reg.cnt == `PMC_TA_LAST) begin
                        q_next.cnt = 4'h0;
                        q_next.st  = pmc_pkg::pmc_data;
                        if (q_reg.is_rd) begin
                            q_next.mdio = q_reg.shreg[15];
                        end
                    end
                end
                pmc_pkg::pmc_data: begin
                    if (q_reg.cnt == `PMC_DATA_LAST) begin
                        q_next.st      = pmc_pkg::pmc_idle;
                        q_next.pre_ok  = 1'b0;
                        q_next.mdio_oe = 1'b0;
                        q_next.mdio    = 1'b0;
                        q_next.cnt     = 4'h0;
                        if (!q_reg.is_rd) begin
                            q_next.wr_stb  = 1'b1;
                            q_next.wr_data = hdr_bits;
                        end
                    end else begin
                        q_next.cnt = q_reg.cnt + 4'h1;
                        if (q_reg.is_rd) begin
                            q_next.shreg = {q_reg.shreg[14:0], 1'b0};
                            q_next.mdio  = q_reg.shreg[14];
                        end else begin
                            q_next.shreg = hdr_bits;
                        end
                    end
                end
                default: begin
                    q_next.st      = pmc_pkg::pmc_idle;
                    q_next.mdio_oe = 1'b0;
                end
            endcase
        end

        // register writes, one cycle after the last data bit
        if (q_reg.wr_stb) begin
            if (q_reg.wr_addr == `PMC_REG_XCTRL) begin
                q_next.xctrl = q_reg.wr_data; // R4 R5 R7
            end else if (q_reg.wr_addr == `PMC_REG_INT) begin
                q_next.int_en = q_reg.wr_data[15:8]; // R9 R10 R11 R12 R13 R14 R15 R16
            end
        end

        // status bits: event wins over read clear
        q_next.int_st = (q_reg.int_st & ~{8{rd_clr}}) | evt_i; // R17

        // strap capture once the synchronisers hold pin levels
        if (!q_reg.strap_done) begin
            if (q_reg.strap_cnt == `PMC_STRAP_WAIT) begin
                q_next.strap      = sync_q[4:2]; // R19
                q_next.strap_done = 1'b1;
            end else begin
                q_next.strap_cnt = q_reg.strap_cnt + 2'h1;
            end
        end

        // registered outputs
        q_next.intr     = |(q_next.int_st & q_next.int_en); // R18
        q_next.pwrdn_en = !q_next.xctrl[`PMC_BIT_PWRDN_DIS]; // R4
        q_next.lat_rand = MII_VARIANT && q_next.xctrl[`PMC_BIT_LAT_RAND]; // R5
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign mdio_o                       = q_reg.mdio;
    assign mdio_oe_o                    = q_reg.mdio_oe;
    assign intr_o                       = q_reg.intr;
    assign energy_detect_powerdown_en_o = q_reg.pwrdn_en;
    assign rx_latency_random_o          = q_reg.lat_rand;

    // ======================================================================
    // receive preamble handling
    pmc_preamble u_pre (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .mode10_i  (rx_mode10_i),
        .restore_i (q_reg.xctrl[`PMC_BIT_PRE_REST]), // R7 R8
        .rx_dv_i   (rx_dv_i),
        .rxd_i     (rxd_i),
        .rx_dv_o   (rx_dv_o),
        .rxd_o     (rxd_o)
    );

    // ======================================================================
    // checks
    sequence s_int_write;
        q_reg.wr_stb && (q_reg.wr_addr == `PMC_REG_INT);
    endsequence

    sequence s_read_header;
        mdc_rise && (q_reg.st == pmc_pkg::pmc_hdr) && (q_reg.cnt == `PMC_HDR_LAST)
            && (hdr_op == `PMC_OP_RD) && (hdr_phy == PHY_ADDR);
    endsequence

    a_int_en_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9 R16
        s_int_write |=> q_reg.int_en == $past(q_reg.wr_data[15:8]))
        else $error("interrupt enables not loaded by write");
    a_xctrl_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
        q_reg.wr_stb && (q_reg.wr_addr == `PMC_REG_XCTRL)
            |=> q_reg.xctrl == $past(q_reg.wr_data))
        else $error("expanded control not loaded by write");
    a_event_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
        (evt_i != 8'h00) |=> ((q_reg.int_st & $past(evt_i)) == $past(evt_i)))
        else $error("event did not set its status bit");
    a_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
        rd_clr |=> q_reg.int_st == $past(evt_i))
        else $error("status not cleared by read");
    a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R18
        ##1 (intr_o == |(q_reg.int_st & q_reg.int_en)))
        else $error("interrupt output disagrees with enabled status");
    a_pwrdn_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
        ##1 (energy_detect_powerdown_en_o == !q_reg.xctrl[`PMC_BIT_PWRDN_DIS]))
        else $error("power-down enable does not follow control bit");
    a_latency_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
        ##1 (rx_latency_random_o == (MII_VARIANT && q_reg.xctrl[`PMC_BIT_LAT_RAND])))
        else $error("latency select does not follow control bit");
    a_strap_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R19
        q_reg.strap_done |=> q_reg.strap_done && $stable(q_reg.strap))
        else $error("strap status changed after capture");
    a_read_turn: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1 R2 R3
        s_read_header |=> !mdio_oe_o && (q_reg.st == pmc_pkg::pmc_ta)
            && ((q_reg.wr_addr != `PMC_REG_STRAP)
            || ((q_reg.shreg[`PMC_BIT_NAND] == q_reg.strap[2])
            && (q_reg.shreg[`PMC_BIT_RMII] == (q_reg.strap[1] && !MII_VARIANT))
            && (q_reg.shreg[`PMC_BIT_MII] == (q_reg.strap[0] && MII_VARIANT))))
            ##1 (q_reg.st == pmc_pkg::pmc_ta)[*1])
        else $error("read turnaround or strap snapshot wrong");
    a_strap_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R19
        q_reg.wr_stb && (q_reg.wr_addr == `PMC_REG_STRAP) |=> $stable(q_reg.strap))
        else $error("strap status changed by a write");
    a_status_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
        q_reg.wr_stb && (q_reg.wr_addr == `PMC_REG_INT) && (evt_i == 8'h00)
            |=> q_reg.int_st == $past(q_reg.int_st))
        else $error("status bits changed by a write");

endmodule

// >>> logic/pmc_defs.svh
// constants for the phy mode control and interrupt register subset
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ==========================================================================
// register offsets
`define PMC_REG_STRAP      5'h17
`define PMC_REG_XCTRL      5'h18
`define PMC_REG_INT        5'h1b

// ==========================================================================
// field positions
`define PMC_BIT_PWRDN_DIS  11
`define PMC_BIT_LAT_RAND   10
`define PMC_BIT_PRE_REST   6
`define PMC_BIT_NAND       5
`define PMC_BIT_RMII       1
`define PMC_BIT_MII        0

// ==========================================================================
// reset values
`define PMC_XCTRL_RST      16'h0801
`define PMC_INT_EN_RST     8'h00
`define PMC_INT_ST_RST     8'h00

// ==========================================================================
// management frame and timing counts
`define PMC_OP_RD          2'h2
`define PMC_OP_WR          2'h1
`define PMC_HDR_LAST       4'hb
`define PMC_TA_LAST        4'h1
`define PMC_DATA_LAST      4'hf
`define PMC_STRAP_WAIT     2'h2
`define PMC_PRE_NIBBLES    4'he

`endif

// >>> logic/pmc_pkg.sv
// types for the phy mode control and interrupt register subset
package pmc_pkg;

    typedef enum logic [2:0] {
        pmc_idle  = 3'h0,
        pmc_start = 3'h1,
        pmc_hdr   = 3'h3,
        pmc_ta    = 3'h2,
        pmc_data  = 3'h6
    } pmc_mdio_st_t;

    typedef struct packed {
        logic         dv_prev;
        logic         dropping;
        logic [3:0]   cnt;
        logic         dv;
        logic [3:0]   rxd;
    } pmc_pre_t;

endpackage

// >>> logic/pmc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pmc_sync #(
    parameter int W = 5
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pmc_sync_t;

    pmc_sync_t q_reg;
    pmc_sync_t q_next;

    always_comb begin
        q_next    = q_reg;
        q_next.s1 = d_i;
        q_next.s2 = q_reg.s1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg.s2;

endmodule

// >>> logic/pmc_preamble.sv
// receive preamble strip and restore stage
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_preamble (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       mode10_i,
    input  wire logic       restore_i,
    input  wire logic       rx_dv_i,
    input  wire logic [3:0] rxd_i,
    output logic            rx_dv_o,
    output logic      [3:0] rxd_o
);

    pmc_pkg::pmc_pre_t q_reg;
    pmc_pkg::pmc_pre_t q_next;
    logic              start;
    logic              strip;
    logic              drop;

    always_comb begin
        q_next         = q_reg;
        start          = rx_dv_i && !q_reg.dv_prev;
        strip          = mode10_i && !restore_i;
        drop           = start ? strip : q_reg.dropping;
        q_next.dv_prev = rx_dv_i;
        if (start) begin
            q_next.dropping = strip; // R8
            q_next.cnt      = 4'h1;
        end else if (q_reg.dropping) begin
            q_next.cnt      = q_reg.cnt + 4'h1;
            q_next.dropping = (q_reg.cnt + 4'h1) != `PMC_PRE_NIBBLES; // R8
        end
        if (!rx_dv_i) begin
            q_next.dropping = 1'b0;
        end
        q_next.dv  = rx_dv_i && !drop; // R6 R7
        q_next.rxd = (rx_dv_i && !drop) ? rxd_i : 4'h0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign rx_dv_o = q_reg.dv;
    assign rxd_o   = q_reg.rxd;

    sequence s_strip_start;
        $rose(rx_dv_i) && mode10_i && !restore_i;
    endsequence

    sequence s_keep_start;
        $rose(rx_dv_i) && !(mode10_i && !restore_i);
    endsequence

    a_strip_pre: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        s_strip_start |=> !rx_dv_o [*8])
        else $error("preamble nibble leaked while stripping");
    a_sfd_first: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        s_strip_start ##1 rx_dv_i [*8] ##1 rx_dv_i [*6] |=> rx_dv_o)
        else $error("frame did not start after seven preamble bytes");
    a_keep_pre: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
        s_keep_start |=> rx_dv_o && (rxd_o == $past(rxd_i)))
        else $error("preamble nibble dropped while keeping preamble");

endmodule

// >>> tb/pmc_mdio_mgr.sv
// station manager model on the management clock and data pins
`timescale 1ns/1ps
module pmc_mdio_mgr (
    input  wire logic clk_i,
    input  wire logic mdio_i,
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_oe_o
);
    // =====
    // idle: clock stands low, data released
    initial begin
        mdc_o     = 1'b0;
        mdio_o    = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // =====
    // one bit: data changes while mdc low, line sampled at mdc rise
    task automatic one_bit(input logic d, input logic drv, output logic s);
        @(negedge clk_i);
        mdio_oe_o = drv;
        mdio_o    = d;
        repeat (8) @(negedge clk_i);
        mdc_o = 1'b1;
        s     = mdio_i;
        repeat (8) @(negedge clk_i);
        mdc_o = 1'b0;
    endtask

    // =====
    // whole frame: idle, start, op, addresses, turnaround, data
    task automatic xfer(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [17:0] hdr;
        logic        s;
        hdr = {2'b11, 2'b01, (wr ? 2'b01 : 2'b10), pa, ra, 2'b10};
        for (int i = 17; i >= 0; i--) begin
            one_bit(hdr[i], wr || (i > 1), s);
        end
        for (int i = 15; i >= 0; i--) begin
            one_bit(wd[i], wr, s);
            rd[i] = s;
        end
        @(negedge clk_i);
        mdio_oe_o = 1'b0;
    endtask
endmodule

// >>> tb/pmc_regs_tb.sv
// self-checking bench for the mode control and interrupt register subset
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_regs_tb;
    logic        clk_i;
    logic        rst_n_i;
    logic        mdc;
    logic        m_d;
    logic        m_oe;
    logic        d_d;
    logic        d_oe;
    logic        mdio_w;
    logic [2:0]  strap;
    logic [7:0]  evt;
    logic        mode10;
    logic        dv_in;
    logic        dv_out;
    logic        intr;
    logic        pd_en;
    logic        lat_rand;
    logic [3:0]  rxd_in;
    logic [3:0]  rxd_out;
    logic [31:0] seed;
    logic [31:0] r;
    logic [15:0] rd;
    logic [15:0] v;
    logic [7:0]  en;
    logic [3:0]  got[$];
    int          bad_count;
    int          checks;
    int          j;

    // =====
    // clock, wire with pull-up, instances
    always #2.5 clk_i = ~clk_i;
    assign mdio_w = d_oe ? d_d : (m_oe ? m_d : 1'b1);

    pmc_regs pmc_regs_i (
        .clk_i                        (clk_i),
        .rst_n_i                      (rst_n_i),
        .mdc_i                        (mdc),
        .mdio_i                       (mdio_w),
        .mdio_o                       (d_d),
        .mdio_oe_o                    (d_oe),
        .strap_nand_i                 (strap[2]),
        .strap_rmii_i                 (strap[1]),
        .strap_mii_i                  (strap[0]),
        .evt_i                        (evt),
        .rx_mode10_i                  (mode10),
        .rx_dv_i                      (dv_in),
        .rxd_i                        (rxd_in),
        .rx_dv_o                      (dv_out),
        .rxd_o                        (rxd_out),
        .intr_o                       (intr),
        .energy_detect_powerdown_en_o (pd_en),
        .rx_latency_random_o          (lat_rand)
    );

    pmc_mdio_mgr pmc_mdio_mgr_i (
        .clk_i     (clk_i),
        .mdio_i    (mdio_w),
        .mdc_o     (mdc),
        .mdio_o    (m_d),
        .mdio_oe_o (m_oe)
    );

    always @(posedge clk_i) begin
        if (dv_out === 1'b1) begin
            got.push_back(rxd_out);
        end
    end

    // =====
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [4:0] ra, input logic [15:0] val);
        pmc_mdio_mgr_i.xfer(1'b1, 5'h01, ra, val, rd);
    endtask

    task automatic rd_reg(input logic [4:0] ra);
        pmc_mdio_mgr_i.xfer(1'b0, 5'h01, ra, 16'h0000, rd);
    endtask

    task automatic pulse(input logic [7:0] e);
        @(negedge clk_i);
        evt = e;
        @(negedge clk_i);
        evt = 8'h00;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic burst(input int n, input int drop);
        logic [3:0]  sent[$];
        logic [31:0] t;
        got.delete();
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            t      = xs();
            dv_in  = 1'b1;
            rxd_in = t[3:0];
            sent.push_back(t[3:0]);
        end
        @(negedge clk_i);
        dv_in  = 1'b0;
        rxd_in = 4'h0;
        repeat (4) @(negedge clk_i);
        check(16'(got.size()), 16'(n - drop));
        for (int i = 0; i < got.size(); i++) begin
            check(16'(got[i]), 16'(sent[i + drop]));
        end
    endtask

    // =====
    // watchdog
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        final_report();
    end

    // =====
    // main sequence
    initial begin
        seed      = 32'he6ba79d1;
        bad_count = 0;
        checks    = 0;
        clk_i     = 1'b0;
        rst_n_i   = 1'b0;
        evt       = 8'h00;
        mode10    = 1'b0;
        dv_in     = 1'b0;
        rxd_in    = 4'h0;
        r         = xs();
        strap     = r[2:0];
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (8) @(negedge clk_i);
        check(pd_en, 1'b0);
        check(lat_rand, 1'b0);
        rd_reg(`PMC_REG_XCTRL);
        check(rd, `PMC_XCTRL_RST);
        rd_reg(`PMC_REG_INT);
        check(rd, 16'h0000);
        r = xs();
        wr_reg(`PMC_REG_STRAP, r[15:0]);
        rd_reg(`PMC_REG_STRAP);
        check(rd, {10'h000, strap[2], 4'h0, strap[0]});
        pmc_mdio_mgr_i.xfer(1'b0, 5'h02, `PMC_REG_XCTRL, 16'h0000, rd);
        check(rd, 16'hffff);
        for (int k = 0; k < 3; k++) begin
            r = xs();
            v = (k == 0) ? 16'hffff : ((k == 1) ? 16'h0000 : r[15:0]);
            wr_reg(`PMC_REG_XCTRL, v);
            rd_reg(`PMC_REG_XCTRL);
            check(rd, v);
            check(pd_en, !v[11]);
            check(lat_rand, v[10]);
        end
        for (int k = 0; k < 8; k++) begin
            r  = xs();
            j  = (k + 1 + (r[2:0] % 7)) % 8;
            en = 8'h01 << k;
            wr_reg(`PMC_REG_INT, {en, r[23:16]});
            rd_reg(`PMC_REG_INT);
            check(rd, {en, 8'h00});
            pulse(8'h01 << j);
            check(intr, 1'b0);
            pulse(en);
            check(intr, 1'b1);
            rd_reg(`PMC_REG_INT);
            check(rd, {en, en | (8'h01 << j)});
            rd_reg(`PMC_REG_INT);
            check(rd, {en, 8'h00});
            check(intr, 1'b0);
        end
        for (int k = 0; k < 5; k++) begin
            r    = xs();
            v    = r[15:0];
            v[6] = k[0];
            wr_reg(`PMC_REG_XCTRL, v);
            mode10 = k[1] | k[2];
            burst((k == 4) ? 15 : 16 + r[19:16], (mode10 && !v[6]) ? 14 : 0);
        end
        final_report();
    end
endmodule
